// *** src/clkos_top.sv ***
// Clock output select: machine clocks, strap, glitch-free output mux, APB
//
// What this block does
// - Output toggles twice per machine cycle
// - Machine cycle spans output falling edges
// - Disable bit written one stops pin drive
// - Select bits 7:6 route subsystem A-D clock
// - Selection resets to subsystem A
// - Strap sampled at reset; zero bypasses PLL
// - Strap one doubles the reference clock
// - Off-function pin low makes output high-Z
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "clkos_cfg.svh"

module clkos_top #(
	parameter int MACH_DIV = 1 // Core ticks per machine clock half period
) (
	// APB clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins from the board
	input wire logic reference_clock_in,
	input wire logic clock_mode_strap,
	input wire logic emulation_off_pin,
	// Clock output pin and status
	output logic machine_clock_out,
	output logic machine_clock_out_oe,
	output logic machine_cycle_start
);
	import clkos_pkg::*;

	// ==========================================
	// Pin synchronisers: three flops, accept once stages two and three agree
	logic [2:0] ref_sync_reg; // Reference clock stages
	logic [2:0] strap_sync_reg; // Strap stages
	logic [2:0] emu_sync_reg; // Emulation/off stages
	logic ref_reg; // Filtered reference level
	logic ref_prev_reg; // Previous filtered level, for edges
	logic strap_level_reg; // Filtered strap level
	logic emu_level_reg; // Filtered emulation/off level

	// Shift the raw pins in; stage one is read only by stage two
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_sync_reg <= 3'h0;
			strap_sync_reg <= 3'h0;
			emu_sync_reg <= 3'h7;
		end else begin
			ref_sync_reg <= {ref_sync_reg[1:0], reference_clock_in};
			strap_sync_reg <= {strap_sync_reg[1:0], clock_mode_strap};
			emu_sync_reg <= {emu_sync_reg[1:0], emulation_off_pin};
		end
	end

	// Filter: a level counts only when stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_reg <= 1'b0;
			ref_prev_reg <= 1'b0;
			strap_level_reg <= 1'b0;
			emu_level_reg <= 1'b1;
		end else begin
			ref_prev_reg <= ref_reg;
			if (ref_sync_reg[1] == ref_sync_reg[2]) begin
				ref_reg <= ref_sync_reg[2];
			end
			if (strap_sync_reg[1] == strap_sync_reg[2]) begin
				strap_level_reg <= strap_sync_reg[2];
			end
			if (emu_sync_reg[1] == emu_sync_reg[2]) begin
				emu_level_reg <= emu_sync_reg[2];
			end
		end
	end

	// ==========================================
	// Clock mode strap capture
	logic [2:0] fill_reg; // Cycles since release, until the filtered level is valid
	logic strap_done_reg; // Strap has been captured
	logic strap_reg; // Captured strap: 1 doubles, 0 bypasses

	// Capture once after release; a reset constant cannot hold a pin level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fill_reg <= 3'h0;
			strap_done_reg <= 1'b0;
			strap_reg <= 1'b0;
		end else if (!strap_done_reg) begin
			if (fill_reg == `CLKOS_SYNC_FILL) begin
				// Board keeps the strap steady across reset
				strap_reg <= strap_level_reg;
				strap_done_reg <= 1'b1;
			end else begin
				// One edge more than the three stages, so the filter has caught up
				fill_reg <= fill_reg + 3'h1;
			end
		end
	end

	// ==========================================
	// Core tick: bypass uses rising edges, doubling uses both edges
	logic ref_rise; // Reference rising edge
	logic ref_fall; // Reference falling edge
	logic core_tick; // One tick per core clock period

	assign ref_rise = ref_reg & ~ref_prev_reg;
	assign ref_fall = ~ref_reg & ref_prev_reg;
	// Doubling adds the falling edges; ticks wait for the strap
	assign core_tick = strap_done_reg & (ref_rise | (strap_reg & ref_fall));

	// ==========================================
	// Subsystem machine clocks, one divider each
	logic [3:0] sub_clk_reg; // A..D machine clocks
	logic [31:0] div_cnt_reg [4]; // Half-period counters

	// Each half period lasts MACH_DIV core ticks
	for (genvar i = 0; i < 4; i++) begin : g_sub
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				sub_clk_reg[i] <= 1'b0;
				div_cnt_reg[i] <= 32'h0000_0000;
			end else if (core_tick) begin
				if (div_cnt_reg[i] == 32'(MACH_DIV - 1)) begin
					div_cnt_reg[i] <= 32'h0000_0000;
					sub_clk_reg[i] <= ~sub_clk_reg[i];
				end else begin
					div_cnt_reg[i] <= div_cnt_reg[i] + 32'h0000_0001;
				end
			end
		end
	end

	// ==========================================
	// Register file
	logic [1:0] sel_reg; // Source selection, GPIO bits 7:6
	logic processor_mode_status_reg; // Clock output disable bit
	logic emu_off_en_reg; // Emulation pin works as off function
	logic wr_en; // Write completes this edge
	logic sel_written_reg; // Selection has been written since reset

	assign wr_en = psel & penable & pready & pwrite;

	// Software writes land at the completing edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_reg <= `CLKOS_SEL_RST;
			processor_mode_status_reg <= 1'b0;
			emu_off_en_reg <= 1'b0;
			sel_written_reg <= 1'b0;
		end else if (wr_en) begin
			if (paddr == `CLKOS_GPIO_OFF) begin
				sel_reg <= pwdata[`CLKOS_SEL_MSB:`CLKOS_SEL_LSB];
				sel_written_reg <= 1'b1;
			end else if (paddr == `CLKOS_MODE_OFF) begin
				processor_mode_status_reg <= pwdata[`CLKOS_OFF_BIT];
			end else if (paddr == `CLKOS_CONF_OFF) begin
				emu_off_en_reg <= pwdata[`CLKOS_EMU_BIT];
			end
		end
	end

	// ==========================================
	// Glitch-free switch-over
	clkos_state_t state_reg; // Switch-over state
	logic [1:0] active_reg; // Source now on the pin

	// Leave the old source only when it is low, join the new one when it is low;
	// the pin is held low between, so no phase is ever shortened
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= CLKOS_RUN;
			active_reg <= `CLKOS_SEL_RST;
		end else begin
			case (state_reg)
				CLKOS_RUN: begin
					if (sel_reg != active_reg) begin
						state_reg <= CLKOS_DRAIN;
					end
				end
				CLKOS_DRAIN: begin
					// Wait out the high phase of the old source
					if (!sub_clk_reg[active_reg]) begin
						state_reg <= CLKOS_HOLD;
					end
				end
				CLKOS_HOLD: begin
					// Join the new source in its low phase
					if (!sub_clk_reg[sel_reg]) begin
						active_reg <= sel_reg;
						state_reg <= CLKOS_RUN;
					end
				end
				default: begin
					state_reg <= CLKOS_RUN;
				end
			endcase
		end
	end

	// ==========================================
	// Output pin drive
	logic out_next; // Next pin level

	// In DRAIN the old source still drives until it is low
	always_comb begin
		if (state_reg == CLKOS_HOLD) begin
			out_next = 1'b0;
		end else begin
			out_next = sub_clk_reg[active_reg];
		end
	end

	// Pin follows the machine clock; falling edge opens a machine cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			machine_clock_out <= 1'b0;
			machine_clock_out_oe <= 1'b0;
			machine_cycle_start <= 1'b0;
		end else begin
			machine_clock_out <= out_next;
			machine_cycle_start <= machine_clock_out & ~out_next;
			machine_clock_out_oe <= ~processor_mode_status_reg
				& ~(emu_off_en_reg & ~emu_level_reg);
		end
	end

	// ==========================================
	// APB answer: one wait state, read data registered
	logic [31:0] rd_next; // Decoded read word
	logic hit; // Address is mapped

	// Unmapped addresses answer with an error and zero data
	always_comb begin
		rd_next = `CLKOS_DATA_RST;
		hit = 1'b1;
		if (paddr == `CLKOS_GPIO_OFF) begin
			rd_next[`CLKOS_SEL_MSB:`CLKOS_SEL_LSB] = sel_reg;
		end else if (paddr == `CLKOS_MODE_OFF) begin
			rd_next[`CLKOS_OFF_BIT] = processor_mode_status_reg;
		end else if (paddr == `CLKOS_CONF_OFF) begin
			rd_next[`CLKOS_EMU_BIT] = emu_off_en_reg;
		end else if (paddr == `CLKOS_STAT_OFF) begin
			rd_next[`CLKOS_STAT_STRAP] = strap_reg;
			rd_next[`CLKOS_STAT_ACT_MSB:`CLKOS_STAT_ACT_LSB] = active_reg;
			rd_next[`CLKOS_STAT_BUSY] = (state_reg != CLKOS_RUN);
		end else begin
			hit = 1'b0;
		end
	end

	// Ready rises in the second access cycle and drops right after
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `CLKOS_DATA_RST;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~hit;
			if (psel & penable & ~pready & ~pwrite) begin
				prdata <= rd_next;
			end
		end
	end

	// ==========================================
	// Checks
	clk_off_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
		processor_mode_status_reg |=> !machine_clock_out_oe)
		else $error("clock output driven while disabled");
	emu_off_hiz_a: assert property (@(posedge pclk) disable iff (!presetn)
		(emu_off_en_reg && !emu_level_reg) |=> !machine_clock_out_oe)
		else $error("clock output driven in off mode");
	pin_drive_on_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!processor_mode_status_reg && !(emu_off_en_reg && !emu_level_reg))
		|=> machine_clock_out_oe)
		else $error("clock output not driven");
	sel_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		!sel_written_reg |-> (sel_reg == 2'h0 && active_reg == 2'h0))
		else $error("selection left subsystem A without a write");
	bypass_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
		(strap_done_reg && !strap_reg) |-> (core_tick == ref_rise))
		else $error("falling edge ticks in bypass mode");
	double_tick_a: assert property (@(posedge pclk) disable iff (!presetn)
		(strap_done_reg && strap_reg && (ref_fall || ref_rise)) |-> core_tick)
		else $error("missing tick in doubling mode");
	route_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == CLKOS_RUN) |=> machine_clock_out == $past(sub_clk_reg[active_reg]))
		else $error("pin does not follow selected clock");
	cycle_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(machine_clock_out) |-> machine_cycle_start)
		else $error("machine cycle not started on falling edge");
	switch_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == CLKOS_HOLD) |=> !machine_clock_out)
		else $error("pin not held low during switch-over");
	toggle_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
		(state_reg == CLKOS_RUN && $changed(sub_clk_reg[active_reg]))
		|=> $changed(machine_clock_out))
		else $error("pin missed a machine clock toggle");

endmodule

// *** src/clkos_cfg.svh ***
// Constants for the clock output select block: offsets, fields, resets
`ifndef CLKOS_CFG_SVH
`define CLKOS_CFG_SVH

// ==========================================
// Register byte offsets
`define CLKOS_GPIO_OFF 12'h000
`define CLKOS_MODE_OFF 12'h004
`define CLKOS_CONF_OFF 12'h008
`define CLKOS_STAT_OFF 12'h00C

// ==========================================
// Field positions
`define CLKOS_SEL_LSB 6
`define CLKOS_SEL_MSB 7
`define CLKOS_OFF_BIT 0
`define CLKOS_EMU_BIT 0
`define CLKOS_STAT_STRAP 0
`define CLKOS_STAT_ACT_LSB 1
`define CLKOS_STAT_ACT_MSB 2
`define CLKOS_STAT_BUSY 3

// ==========================================
// Reset values
`define CLKOS_SEL_RST 2'h0
`define CLKOS_DATA_RST 32'h0000_0000

// ==========================================
// Timing counts
`define CLKOS_SYNC_FILL 3'h4

`endif

// *** src/clkos_pkg.sv ***
// Types shared by the clock output select block
package clkos_pkg;

	// ==========================================
	// Source selection code
	typedef logic [1:0] clkos_sel_t;

	// ==========================================
	// Switch-over state machine, one-hot
	typedef enum logic [2:0] {
		CLKOS_RUN = 3'b001,
		CLKOS_DRAIN = 3'b010,
		CLKOS_HOLD = 3'b100
	} clkos_state_t;

endpackage

// *** dv/clkos_board.sv ***
// Board model: reference clock source, strap holder, clock output watcher
`timescale 1ns/1ps

module clkos_board #(
	parameter int REF_HALF = 5, // Reference clock half period in pclk cycles
	parameter int MIN_HIGH = 5 // Shortest legal high phase of the output
) (
	// Clock
	input wire logic pclk,
	// Strap level wanted by the bench, changed only in reset
	input wire logic strap_level,
	// Pins into the device
	output logic reference_clock_in,
	output logic clock_mode_strap,
	// Clock output pin from the device
	input wire logic machine_clock_out,
	input wire logic machine_clock_out_oe,
	// Count of runt high pulses seen
	output logic [7:0] runt_count
);
	int ref_cnt = 0; // Cycles in the current reference level
	int high_len = 0; // Length of the current high phase

	// ==========================================
	// Strap driven steadily; the bench only moves it during reset
	assign clock_mode_strap = strap_level;

	// ==========================================
	// Reference clock, each level well above the synchroniser's minimum
	initial reference_clock_in = 1'b0;
	always @(posedge pclk) begin
		ref_cnt <= (ref_cnt == REF_HALF - 1) ? 0 : ref_cnt + 1;
		if (ref_cnt == REF_HALF - 1) begin
			reference_clock_in <= ~reference_clock_in;
		end
	end

	// ==========================================
	// Runt watch: a short high phase would upset board logic clocked by it
	initial runt_count = 8'h00;
	always @(posedge pclk) begin
		if (machine_clock_out === 1'b1) begin
			high_len <= high_len + 1;
		end else begin
			if (high_len > 0 && high_len < MIN_HIGH && machine_clock_out_oe === 1'b1) begin
				runt_count <= runt_count + 8'h01;
			end
			high_len <= 0;
		end
	end
endmodule

// *** dv/clock_output_select_tb.sv ***
// Testbench for the clock output select block
`timescale 1ns/1ps
`include "clkos_cfg.svh"

module clock_output_select_tb;
	// Bench-driven inputs
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic emu_n = 1'b1; // Emulation off pin, high = not off
	logic strap_level = 1'b0;
	// Design outputs and board pins
	logic [31:0] prdata;
	logic pready, pslverr, ref_clk, strap, mco, oe, mcs;
	logic [7:0] runts;
	// Bookkeeping
	int err_total = 0;
	int tests_run = 0;
	logic [31:0] rd;
	logic er;

	always #5 pclk = ~pclk;

	clkos_top #(.MACH_DIV(1)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.reference_clock_in(ref_clk), .clock_mode_strap(strap),
		.emulation_off_pin(emu_n), .machine_clock_out(mco),
		.machine_clock_out_oe(oe), .machine_cycle_start(mcs));

	clkos_board board (.pclk(pclk), .strap_level(strap_level),
		.reference_clock_in(ref_clk), .clock_mode_strap(strap),
		.machine_clock_out(mco), .machine_clock_out_oe(oe), .runt_count(runts));

	// ==========================================
	// Verdict, the single exit of the run
	task final_report;
		if (err_total == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// Compare one value, unknowns never match
	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// A wait that used up its bound counts as a mismatch and ends the run
	task timeout_fail;
		err_total++;
		final_report();
	endtask

	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			timeout_fail();
		end
	endtask

	// Read a register and compare the whole word
	task rchk(input logic [11:0] a, input logic [31:0] exp, input string what);
		apb(1'b0, a, 32'h0000_0000);
		chk(what, exp, rd);
	endtask

	// Reset with a given strap; the strap only moves while reset is held
	task do_reset(input logic s);
		@(posedge pclk);
		presetn <= 1'b0;
		strap_level <= s;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		repeat (8) @(posedge pclk);
	endtask

	// Cycles between machine cycle starts, clock low at the second start
	task period(input int exp);
		int n;
		int m;
		n = 0;
		m = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (mcs !== 1'b1 && n < 100);
		if (mcs !== 1'b1) begin
			timeout_fail();
		end
		do begin
			@(posedge pclk);
			m++;
		end while (mcs !== 1'b1 && m < 100);
		if (mcs !== 1'b1) begin
			timeout_fail();
		end
		chk("cycle_len", exp, m);
		chk("clk_at_start", 32'h0, {31'h0, mco});
	endtask

	// Check the pin enable after the pin path has settled
	task oe_chk(input logic exp);
		repeat (8) @(posedge pclk);
		chk("oe", {31'h0, exp}, {31'h0, oe});
	endtask

	// ==========================================
	// Main sequence
	initial begin
		int n;
		do_reset(1'b0);
		rchk(`CLKOS_GPIO_OFF, 32'h0000_0000, "gpio_rst");
		rchk(`CLKOS_MODE_OFF, 32'h0000_0000, "mode_rst");
		rchk(`CLKOS_STAT_OFF, 32'h0000_0000, "stat_bypass");
		period(20);
		// Every source code; codes 1 to 3 each followed by a completed switch
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, `CLKOS_GPIO_OFF, 32'(k) << 6);
			rchk(`CLKOS_GPIO_OFF, 32'(k) << 6, "gpio_sel");
			n = 0;
			do begin
				apb(1'b0, `CLKOS_STAT_OFF, 32'h0000_0000);
				n++;
			end while (rd[3] !== 1'b0 && n < 40);
			if (rd[3] !== 1'b0) begin
				timeout_fail();
			end
			chk("stat_active", 32'(k) << 1, rd);
			period(20);
		end
		chk("runts", 32'h0, {24'h0, runts});
		oe_chk(1'b1);
		apb(1'b1, `CLKOS_MODE_OFF, 32'h0000_0001);
		oe_chk(1'b0);
		apb(1'b1, `CLKOS_MODE_OFF, 32'h0000_0000);
		oe_chk(1'b1);
		emu_n <= 1'b0;
		oe_chk(1'b1);
		apb(1'b1, `CLKOS_CONF_OFF, 32'h0000_0001);
		oe_chk(1'b0);
		emu_n <= 1'b1;
		oe_chk(1'b1);
		apb(1'b0, 12'h010, 32'h0000_0000);
		chk("unmapped_err", 32'h1, {31'h0, er});
		chk("unmapped_data", 32'h0, rd);
		do_reset(1'b1);
		rchk(`CLKOS_STAT_OFF, 32'h0000_0001, "stat_doubled");
		period(10);
		final_report();
	end
endmodule
